//--- plrc_ctrl.sv
// Power loss restore controller running from the standby domain.
`timescale 1ns/1ps
// Functional notes
// - On soft-off or total power loss the controller starts watching the standby rail.
// - Standby present for a full 30 s after power-down marks an orderly switch-off.
// - Standby gone before 30 s marks an AC power loss.
// - Turn-on policy powers the system up when standby returns after a loss.
// - Remain-off policy keeps the system off when standby returns after a loss.
// - Last-state policy restores the on or off condition held before the loss.
// - The 30 s window is used only under the last-state policy.
// - A loss within 30 s of an orderly shutdown may leave the last state recorded as on.
// - Without a standby rail the policy setting has no effect.
module plrc_ctrl #(
  parameter longint unsigned WINDOW_CYCLES = plrc_pkg::WINDOW_CYC
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Supply and system pins
  input  wire logic       stby_ok,
  input  wire logic       sys_on,
  input  wire logic       stby_rail_present,
  // Configuration
  input  wire logic [1:0] restore_policy,
  // Outputs
  output logic            pwr_on_req,
  output logic            last_state_on,
  output logic            ac_loss_seen,
  output logic            orderly_off_seen
);

  // ----------------------------------------
  // Input synchronisation
  // ----------------------------------------
  logic stby_s;
  logic on_s;
  logic rail_s;

  plrc_sync u_sync_stby (.clk_sys(clk_sys), .rst(rst), .din(stby_ok), .dout(stby_s));
  plrc_sync u_sync_on   (.clk_sys(clk_sys), .rst(rst), .din(sys_on),  .dout(on_s));
  plrc_sync u_sync_rail (.clk_sys(clk_sys), .rst(rst), .din(stby_rail_present), .dout(rail_s));

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    plrc_pkg::plrc_state_t   st;
    logic [plrc_pkg::CNT_W-1:0] cnt;
    logic                    last_on;
    logic                    ac_loss;
    logic                    orderly;
    logic                    req;
  } plrc_ctrl_t;

  plrc_ctrl_t r_ff;
  plrc_ctrl_t nxt_r;
  logic [1:0] pol;

  localparam logic [plrc_pkg::CNT_W-1:0] WIN_LAST = plrc_pkg::CNT_W'(WINDOW_CYCLES - 1);

  // Fourth encoding folds onto remain-off.
  always_comb begin
    if (restore_policy == plrc_pkg::POL_TURN_ON) begin
      pol = plrc_pkg::POL_TURN_ON;
    end else if (restore_policy == plrc_pkg::POL_LAST_STATE) begin
      pol = plrc_pkg::POL_LAST_STATE;
    end else begin
      pol = plrc_pkg::POL_REMAIN_OFF;
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt_r     = r_ff;
    nxt_r.req = 1'b0;
    case (r_ff.st)
      plrc_pkg::PLRC_ST_ON: begin
        nxt_r.last_on = 1'b1;
        if (!stby_s) begin
          nxt_r.ac_loss = 1'b1;
          nxt_r.st      = plrc_pkg::PLRC_ST_LOST;
        end else if (!on_s) begin
          nxt_r.cnt = '0;
          nxt_r.st  = plrc_pkg::PLRC_ST_WATCH;
        end
      end
      plrc_pkg::PLRC_ST_WATCH: begin
        // Last state stays on while the window runs, so an early loss restores on.
        if (pol != plrc_pkg::POL_LAST_STATE) begin
          nxt_r.last_on = 1'b0;
          nxt_r.orderly = 1'b1;
          nxt_r.st      = plrc_pkg::PLRC_ST_OFF;
        end else if (!stby_s) begin
          nxt_r.ac_loss = 1'b1;
          nxt_r.st      = plrc_pkg::PLRC_ST_LOST;
        end else if (on_s) begin
          nxt_r.st = plrc_pkg::PLRC_ST_ON;
        end else if (r_ff.cnt == WIN_LAST) begin
          nxt_r.last_on = 1'b0;
          nxt_r.orderly = 1'b1;
          nxt_r.st      = plrc_pkg::PLRC_ST_OFF;
        end else begin
          nxt_r.cnt = r_ff.cnt + 1'b1;
        end
      end
      plrc_pkg::PLRC_ST_OFF: begin
        if (!stby_s) begin
          nxt_r.ac_loss = 1'b1;
          nxt_r.st      = plrc_pkg::PLRC_ST_LOST;
        end else if (on_s) begin
          nxt_r.orderly = 1'b0;
          nxt_r.ac_loss = 1'b0;
          nxt_r.st      = plrc_pkg::PLRC_ST_ON;
        end
      end
      plrc_pkg::PLRC_ST_LOST: begin
        if (stby_s) begin
          nxt_r.st = plrc_pkg::PLRC_ST_RESTORE;
        end
      end
      plrc_pkg::PLRC_ST_RESTORE: begin
        nxt_r.st = plrc_pkg::PLRC_ST_OFF;
        if (rail_s) begin
          if (pol == plrc_pkg::POL_TURN_ON) begin
            nxt_r.req = 1'b1;
          end else if (pol == plrc_pkg::POL_LAST_STATE) begin
            nxt_r.req = r_ff.last_on;
          end else begin
            nxt_r.req = 1'b0;
          end
        end
      end
      default: begin
        nxt_r.st = plrc_pkg::PLRC_ST_OFF;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      r_ff    <= '0;
      r_ff.st <= plrc_pkg::PLRC_ST_OFF;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign pwr_on_req       = r_ff.req;
  assign last_state_on    = r_ff.last_on;
  assign ac_loss_seen     = r_ff.ac_loss;
  assign orderly_off_seen = r_ff.orderly;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_watch_start;
    @(posedge clk_sys) disable iff (rst)
      (r_ff.st == plrc_pkg::PLRC_ST_ON && stby_s && !on_s) |=> (r_ff.st == plrc_pkg::PLRC_ST_WATCH && r_ff.cnt == '0);
  endproperty
  a_watch_start: assert property (p_watch_start) else $error("watch did not start");

  property p_orderly;
    @(posedge clk_sys) disable iff (rst)
      (r_ff.st == plrc_pkg::PLRC_ST_WATCH && pol == plrc_pkg::POL_LAST_STATE && stby_s && !on_s
       && r_ff.cnt == WIN_LAST) |=> (r_ff.orderly && !r_ff.last_on && r_ff.st == plrc_pkg::PLRC_ST_OFF);
  endproperty
  a_orderly: assert property (p_orderly) else $error("orderly off not marked");

  property p_loss;
    @(posedge clk_sys) disable iff (rst)
      (r_ff.st == plrc_pkg::PLRC_ST_WATCH && pol == plrc_pkg::POL_LAST_STATE && !stby_s)
      |=> (r_ff.ac_loss && r_ff.last_on);
  endproperty
  a_loss: assert property (p_loss) else $error("loss in window not marked");

  property p_turn_on;
    @(posedge clk_sys) disable iff (rst)
      (r_ff.st == plrc_pkg::PLRC_ST_RESTORE && rail_s && pol == plrc_pkg::POL_TURN_ON) |=> pwr_on_req;
  endproperty
  a_turn_on: assert property (p_turn_on) else $error("turn on missed");

  property p_remain_off;
    @(posedge clk_sys) disable iff (rst)
      (pol == plrc_pkg::POL_REMAIN_OFF && $stable(pol)) |=> !pwr_on_req;
  endproperty
  a_remain_off: assert property (p_remain_off) else $error("remain off violated");

  property p_last_state;
    @(posedge clk_sys) disable iff (rst)
      (r_ff.st == plrc_pkg::PLRC_ST_RESTORE && rail_s && pol == plrc_pkg::POL_LAST_STATE)
      |=> (pwr_on_req == $past(r_ff.last_on));
  endproperty
  a_last_state: assert property (p_last_state) else $error("last state not restored");

  property p_no_window;
    @(posedge clk_sys) disable iff (rst)
      (r_ff.st == plrc_pkg::PLRC_ST_WATCH && pol != plrc_pkg::POL_LAST_STATE) |=> r_ff.st != plrc_pkg::PLRC_ST_WATCH;
  endproperty
  a_no_window: assert property (p_no_window) else $error("window used outside last state");

  property p_no_rail;
    @(posedge clk_sys) disable iff (rst)
      (r_ff.st == plrc_pkg::PLRC_ST_RESTORE && !rail_s) |=> !pwr_on_req;
  endproperty
  a_no_rail: assert property (p_no_rail) else $error("policy acted without rail");

  property p_fourth;
    @(posedge clk_sys) disable iff (rst)
      (restore_policy == 2'h3) |-> (pol == plrc_pkg::POL_REMAIN_OFF);
  endproperty
  a_fourth: assert property (p_fourth) else $error("fourth code not remain off");

  property p_hold_on;
    @(posedge clk_sys) disable iff (rst)
      (r_ff.st == plrc_pkg::PLRC_ST_WATCH && pol == plrc_pkg::POL_LAST_STATE && r_ff.cnt != WIN_LAST)
      |=> r_ff.last_on;
  endproperty
  a_hold_on: assert property (p_hold_on) else $error("last state dropped inside window");

  property p_off_loss;
    @(posedge clk_sys) disable iff (rst)
      (r_ff.st == plrc_pkg::PLRC_ST_OFF && !stby_s) |=> (r_ff.st == plrc_pkg::PLRC_ST_LOST && r_ff.ac_loss);
  endproperty
  a_off_loss: assert property (p_off_loss) else $error("loss from off not watched");

endmodule : plrc_ctrl

//--- plrc_pkg.sv
// Package with constants and types for the power loss restore controller.
package plrc_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ        = 20000000;
  localparam int unsigned WINDOW_SEC    = 30;
  localparam longint unsigned WINDOW_CYC = longint'(WINDOW_SEC) * longint'(CLK_HZ);
  localparam int unsigned CNT_W         = 32;

  // ----------------------------------------
  // Restore policy encodings
  // ----------------------------------------
  localparam logic [1:0] POL_TURN_ON    = 2'h0;
  localparam logic [1:0] POL_REMAIN_OFF = 2'h1;
  localparam logic [1:0] POL_LAST_STATE = 2'h2;

  // ----------------------------------------
  // Controller states
  // ----------------------------------------
  typedef enum logic [2:0] {
    PLRC_ST_OFF,
    PLRC_ST_ON,
    PLRC_ST_WATCH,
    PLRC_ST_LOST,
    PLRC_ST_RESTORE
  } plrc_state_t;

endpackage : plrc_pkg

//--- plrc_sync.sv
// Two flip-flop synchroniser for one level input.
`timescale 1ns/1ps
module plrc_sync (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Data
  input  wire logic din,
  output logic      dout
);

  typedef struct packed {
    logic s1;
    logic s2;
  } plrc_sync_t;

  plrc_sync_t r_ff;
  plrc_sync_t nxt_r;

  always_comb begin
    nxt_r    = r_ff;
    nxt_r.s1 = din;
    nxt_r.s2 = r_ff.s1;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign dout = r_ff.s2;

endmodule : plrc_sync

//--- plrc_supply_model.sv
// Behavioural model of the standby supply and system power switch.
`timescale 1ns/1ps
module plrc_supply_model (
  // Clock
  input  wire logic clk_sys,
  // Bench controls
  input  wire logic ac_on,
  input  wire logic on_cmd,
  input  wire logic off_cmd,
  // Design side
  input  wire logic pwr_on_req,
  output logic      stby_ok,
  output logic      sys_on
);
  // Losing mains takes the standby rail and the system down at once.
  always @(posedge clk_sys) begin
    stby_ok <= ac_on;
    if (!ac_on || off_cmd) begin
      sys_on <= 1'b0;
    end else if (on_cmd || pwr_on_req) begin
      sys_on <= 1'b1;
    end
  end
endmodule : plrc_supply_model

//--- tb_top.sv
// Self-checking testbench for the power loss restore controller.
`timescale 1ns/1ps
module tb_top;
  localparam longint unsigned WIN = 20;
  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  logic       ac_on = 1'b0;
  logic       on_cmd = 1'b0;
  logic       off_cmd = 1'b0;
  logic       rail = 1'b1;
  logic [1:0] pol = 2'h0;
  logic       stby_ok, sys_on, pwr_on_req, last_state_on, ac_loss_seen, orderly_off_seen;
  int         error_cnt = 0;
  int         checks = 0;
  int         pulses = 0;
  int         cyc = 0;

  always #25 clk_sys = ~clk_sys;

  plrc_supply_model plrc_supply_model_i (.clk_sys(clk_sys), .ac_on(ac_on), .on_cmd(on_cmd), .off_cmd(off_cmd),
    .pwr_on_req(pwr_on_req), .stby_ok(stby_ok), .sys_on(sys_on));
  plrc_ctrl #(.WINDOW_CYCLES(WIN)) plrc_ctrl_i (.clk_sys(clk_sys), .rst(rst), .stby_ok(stby_ok), .sys_on(sys_on),
    .stby_rail_present(rail), .restore_policy(pol), .pwr_on_req(pwr_on_req), .last_state_on(last_state_on),
    .ac_loss_seen(ac_loss_seen), .orderly_off_seen(orderly_off_seen));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (pwr_on_req === 1'b1) pulses++;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : step

  task automatic check(input logic v, input logic e, input string m);
    checks++;
    if (v !== e) begin
      error_cnt++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : check

  task automatic pulse_cmd(input logic on);
    if (on) on_cmd <= 1'b1; else off_cmd <= 1'b1;
    step(1);
    on_cmd  <= 1'b0;
    off_cmd <= 1'b0;
    step(6);
  endtask : pulse_cmd

  task automatic bring_on(input logic [1:0] p, input logic r);
    pol <= p;
    rail <= r;
    ac_on <= 1'b1;
    step(4);
    pulse_cmd(1'b1);
  endtask : bring_on

  // Mains drops for ten cycles and returns; restore pulses are counted.
  task automatic loss(input int exp, input logic look);
    pulses = 0;
    ac_on <= 1'b0;
    step(10);
    if (look) check(ac_loss_seen, 1'b1, "loss not classed");
    ac_on <= 1'b1;
    step(14);
    check(pulses == exp, 1'b1, "restore pulse count");
  endtask : loss

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_turn_on;
    bring_on(2'h0, 1'b1);
    loss(1, 1'b1);
    check(sys_on, 1'b1, "system not restored");
    pulse_cmd(1'b0);
    check(orderly_off_seen, 1'b1, "turn-on off not orderly at once");
    $display("done turn_on");
  endtask : t_turn_on

  task automatic t_remain_off;
    bring_on(2'h1, 1'b1);
    loss(0, 1'b1);
    bring_on(2'h3, 1'b1);
    loss(0, 1'b1);
    $display("done remain_off");
  endtask : t_remain_off

  task automatic t_last_on;
    bring_on(2'h2, 1'b1);
    check(last_state_on, 1'b1, "last state not on");
    loss(1, 1'b1);
    $display("done last_on");
  endtask : t_last_on

  task automatic t_last_off;
    bring_on(2'h2, 1'b1);
    pulse_cmd(1'b0);
    step(int'(WIN) - 4);
    check(orderly_off_seen, 1'b0, "window ended early");
    step(8);
    check(orderly_off_seen, 1'b1, "window end not orderly");
    check(last_state_on, 1'b0, "last state not off");
    loss(0, 1'b0);
    $display("done last_off");
  endtask : t_last_off

  // A loss inside the window restores power; both the class and the single restore pulse are judged.
  task automatic t_quick;
    bring_on(2'h2, 1'b1);
    pulse_cmd(1'b0);
    check(orderly_off_seen, 1'b0, "window ignored");
    check(last_state_on, 1'b1, "last state dropped in window");
    pulses = 0;
    ac_on <= 1'b0;
    step(10);
    check(ac_loss_seen, 1'b1, "early loss not classed");
    ac_on <= 1'b1;
    step(14);
    check(pulses == 1, 1'b1, "early loss not restored on");
    pulse_cmd(1'b0);
    $display("done quick_loss");
  endtask : t_quick

  task automatic t_no_rail;
    bring_on(2'h0, 1'b0);
    loss(0, 1'b0);
    rail <= 1'b1;
    $display("done no_rail");
  endtask : t_no_rail

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic summarize;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end

  initial begin
    step(20);
    rst <= 1'b0;
    step(2);
    t_turn_on();
    t_remain_off();
    t_last_on();
    t_last_off();
    t_quick();
    t_no_rail();
    summarize();
  end
endmodule : tb_top
